// File: bcd_assertions.sv
module bcd_assertions (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic busy,
    input wire logic interrupt_enable,
    input wire logic clock_pause_mode,
    input wire logic oscillator_freeze_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic dph_r;
    logic dph_nxt;
    logic ctl_r;
    logic ctl_nxt;
    logic start_w;
    // write data phase tracking
    always_comb begin
        dph_nxt = hready ? (hsel && htrans[1] && hwrite) : dph_r;
        ctl_nxt = hready ? (haddr == {24'h0, bcd_pkg::ADDR_CTRL}) : ctl_r;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dph_r <= 1'b0;
            ctl_r <= 1'b0;
        end else begin
            dph_r <= dph_nxt;
            ctl_r <= ctl_nxt;
        end
    end
    assign start_w = dph_r && ctl_r && hready && hwdata[bcd_pkg::CTRL_START_BIT];
    a_busy_min_two: assert property ($rose(busy) |-> busy [*2])
        else $error("busy shorter than two clocks");
    a_busy_bounded: assert property ($rose(busy) |-> ##[1:80] !busy)
        else $error("execution longer than eighty clocks");
    a_start_cause: assert property ($rose(busy) |-> $past(start_w))
        else $error("busy rose without a start write");
    a_start_gated: assert property ($rose(busy) |->
        !$past(clock_pause_mode) && !$past(oscillator_freeze_mode))
        else $error("start accepted in standby");
    a_ie_change: assert property ($changed(interrupt_enable) |->
        $fell(busy) || $past(dph_r))
        else $error("interrupt enable changed without cause");
    a_pause_entry: assert property ($rose(clock_pause_mode) |-> $fell(busy))
        else $error("pause mode entered outside completion");
    a_freeze_entry: assert property ($rose(oscillator_freeze_mode) |-> $fell(busy))
        else $error("freeze mode entered outside completion");
    a_modes_hold: assert property (
        ($fell(clock_pause_mode) || $fell(oscillator_freeze_mode)) |-> $past(dph_r))
        else $error("standby mode left without a write");
    c_pause: cover property ($rose(clock_pause_mode));
    c_freeze: cover property ($rose(oscillator_freeze_mode));
    c_ie_set: cover property ($rose(interrupt_enable));
endmodule : bcd_assertions

bind bcd_core bcd_assertions u_chk (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .busy(busy),
    .interrupt_enable(interrupt_enable), .clock_pause_mode(clock_pause_mode),
    .oscillator_freeze_mode(oscillator_freeze_mode));

// File: bcd_core.sv
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
module bcd_core (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic busy,
    output logic interrupt_enable,
    output logic clock_pause_mode,
    output logic oscillator_freeze_mode
);

    function automatic logic [2:0] op_length(input logic [3:0] op, input logic [1:0] src);
        case (op)
            bcd_pkg::OP_BR_CARRY, bcd_pkg::OP_BR_NO_CARRY,
            bcd_pkg::OP_BR_ZERO, bcd_pkg::OP_BR_NONZERO: op_length = bcd_pkg::LEN_2;
            bcd_pkg::OP_BIT_SET, bcd_pkg::OP_BIT_CLEAR: begin
                op_length = (src == bcd_pkg::SRC_ACC) ? bcd_pkg::LEN_3 : bcd_pkg::LEN_4;
            end
            bcd_pkg::OP_DEC_BR: begin
                op_length = (src == bcd_pkg::DEC_REGB || src == bcd_pkg::DEC_REGC) ?
                    bcd_pkg::LEN_2 : bcd_pkg::LEN_3;
            end
            bcd_pkg::OP_INT_ALLOW, bcd_pkg::OP_INT_BLOCK: op_length = bcd_pkg::LEN_3;
            default: op_length = bcd_pkg::LEN_1;
        endcase
    endfunction : op_length

    function automatic logic [3:0] op_clocks(input logic [3:0] op, input logic [1:0] src);
        case (op)
            bcd_pkg::OP_BR_CARRY, bcd_pkg::OP_BR_NO_CARRY,
            bcd_pkg::OP_BR_ZERO, bcd_pkg::OP_BR_NONZERO: op_clocks = bcd_pkg::CLK_6;
            bcd_pkg::OP_BIT_SET, bcd_pkg::OP_BIT_CLEAR: begin
                op_clocks = (src == bcd_pkg::SRC_ACC) ? bcd_pkg::CLK_8 : bcd_pkg::CLK_10;
            end
            bcd_pkg::OP_DEC_BR: begin
                op_clocks = (src == bcd_pkg::DEC_REGB || src == bcd_pkg::DEC_REGC) ?
                    bcd_pkg::CLK_6 : bcd_pkg::CLK_8;
            end
            bcd_pkg::OP_INT_ALLOW, bcd_pkg::OP_INT_BLOCK: op_clocks = bcd_pkg::CLK_6;
            default: op_clocks = bcd_pkg::CLK_2;
        endcase
    endfunction : op_clocks

    // divider mask: select 0..3 gives cpu period of 1, 2, 4, 8 mclk
    function automatic logic [2:0] div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    bcd_pkg::bcd_state_e state_r, state_nxt;
    bcd_pkg::bcd_instr_s instr_r, instr_nxt;
    bcd_pkg::bcd_aphase_s aph_r, aph_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [2:0] div_r, div_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0] psw_r, psw_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] regb_r, regb_nxt;
    logic [7:0] regc_r, regc_nxt;
    logic [7:0] opnd_r, opnd_nxt;
    logic [1:0] clksel_r, clksel_nxt;
    logic pause_r, pause_nxt;
    logic freeze_r, freeze_nxt;
    logic taken_r, taken_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;

    logic cpu_tick;
    logic wr_en;
    logic [7:0] test_byte;
    logic [7:0] dec_val;
    logic cond;
    logic [15:0] pc_seq;
    logic [15:0] pc_jump;
    logic [31:0] rd_word;

    assign cpu_tick = (div_r & div_mask(clksel_r)) == div_mask(clksel_r);
    assign wr_en = aph_r.valid && aph_r.write;

    always_comb begin
        case (instr_r.src)
            bcd_pkg::SRC_PSW: test_byte = psw_r;
            bcd_pkg::SRC_ACC: test_byte = acc_r;
            default: test_byte = opnd_r;
        endcase
        case (instr_r.src)
            bcd_pkg::DEC_REGB: dec_val = regb_r - 8'h01;
            bcd_pkg::DEC_REGC: dec_val = regc_r - 8'h01;
            default: dec_val = opnd_r - 8'h01;
        endcase
        case (instr_r.op)
            bcd_pkg::OP_BR_CARRY: cond = psw_r[bcd_pkg::PSW_CY_BIT];
            bcd_pkg::OP_BR_NO_CARRY: cond = !psw_r[bcd_pkg::PSW_CY_BIT];
            bcd_pkg::OP_BR_ZERO: cond = psw_r[bcd_pkg::PSW_Z_BIT];
            bcd_pkg::OP_BR_NONZERO: cond = !psw_r[bcd_pkg::PSW_Z_BIT];
            bcd_pkg::OP_BIT_SET: cond = test_byte[instr_r.bit_sel];
            bcd_pkg::OP_BIT_CLEAR: cond = !test_byte[instr_r.bit_sel];
            bcd_pkg::OP_DEC_BR: cond = (dec_val != 8'h00);
            default: cond = 1'b0;
        endcase
    end

    assign pc_seq = pc_r + {13'h0000, op_length(instr_r.op, instr_r.src)};
    assign pc_jump = pc_seq + {{8{instr_r.offset[7]}}, instr_r.offset};

    always_comb begin
        case (aph_nxt.addr)
            bcd_pkg::ADDR_CTRL: rd_word = 32'h0000_0000;
            bcd_pkg::ADDR_INSTR: begin
                rd_word = 32'h0000_0000;
                rd_word[bcd_pkg::INSTR_OP_LSB +: 4] = instr_r.op;
                rd_word[bcd_pkg::INSTR_SRC_LSB +: 2] = instr_r.src;
                rd_word[bcd_pkg::INSTR_BIT_LSB +: 3] = instr_r.bit_sel;
                rd_word[bcd_pkg::INSTR_OFS_LSB +: 8] = instr_r.offset;
            end
            bcd_pkg::ADDR_PC: rd_word = {16'h0000, pc_r};
            bcd_pkg::ADDR_PSW: rd_word = {24'h000000, psw_r};
            bcd_pkg::ADDR_ACC: rd_word = {24'h000000, acc_r};
            bcd_pkg::ADDR_REGB: rd_word = {24'h000000, regb_r};
            bcd_pkg::ADDR_REGC: rd_word = {24'h000000, regc_r};
            bcd_pkg::ADDR_OPND: rd_word = {24'h000000, opnd_r};
            bcd_pkg::ADDR_CLKSEL: rd_word = {30'h00000000, clksel_r};
            bcd_pkg::ADDR_STATUS: begin
                rd_word = 32'h0000_0000;
                rd_word[bcd_pkg::STAT_BUSY_BIT] = (state_r == bcd_pkg::ST_EXEC);
                rd_word[bcd_pkg::STAT_PAUSE_BIT] = pause_r;
                rd_word[bcd_pkg::STAT_FREEZE_BIT] = freeze_r;
                rd_word[bcd_pkg::STAT_TAKEN_BIT] = taken_r;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        aph_nxt.valid = hsel && htrans[1] && hready;
        aph_nxt.write = hwrite;
        aph_nxt.addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
        hrdata_nxt = (aph_nxt.valid && !hwrite) ? rd_word : hrdata_r;
        state_nxt = state_r;
        instr_nxt = instr_r;
        cnt_nxt = cnt_r;
        div_nxt = div_r + 3'h1;
        pc_nxt = pc_r;
        psw_nxt = psw_r;
        acc_nxt = acc_r;
        regb_nxt = regb_r;
        regc_nxt = regc_r;
        opnd_nxt = opnd_r;
        clksel_nxt = clksel_r;
        pause_nxt = pause_r;
        freeze_nxt = freeze_r;
        taken_nxt = taken_r;
        // software writes only while nothing executes
        if (wr_en && state_r == bcd_pkg::ST_IDLE) begin
            case (aph_r.addr)
                bcd_pkg::ADDR_CTRL: begin
                    if (hwdata[bcd_pkg::CTRL_START_BIT] && !pause_r && !freeze_r) begin
                        state_nxt = bcd_pkg::ST_EXEC;
                        cnt_nxt = op_clocks(instr_r.op, instr_r.src);
                        div_nxt = 3'h0;
                    end
                end
                bcd_pkg::ADDR_INSTR: begin
                    instr_nxt.op = hwdata[bcd_pkg::INSTR_OP_LSB +: 4];
                    instr_nxt.src = hwdata[bcd_pkg::INSTR_SRC_LSB +: 2];
                    instr_nxt.bit_sel = hwdata[bcd_pkg::INSTR_BIT_LSB +: 3];
                    instr_nxt.offset = hwdata[bcd_pkg::INSTR_OFS_LSB +: 8];
                end
                bcd_pkg::ADDR_PC: pc_nxt = hwdata[15:0];
                bcd_pkg::ADDR_PSW: psw_nxt = hwdata[7:0] & bcd_pkg::PSW_WMASK;
                bcd_pkg::ADDR_ACC: acc_nxt = hwdata[7:0];
                bcd_pkg::ADDR_REGB: regb_nxt = hwdata[7:0];
                bcd_pkg::ADDR_REGC: regc_nxt = hwdata[7:0];
                bcd_pkg::ADDR_OPND: opnd_nxt = hwdata[7:0];
                bcd_pkg::ADDR_CLKSEL: clksel_nxt = hwdata[1:0];
                bcd_pkg::ADDR_STATUS: begin
                    // any write to the status register releases standby
                    pause_nxt = 1'b0;
                    freeze_nxt = 1'b0;
                end
                default: begin
                end
            endcase
        end
        case (state_r)
            bcd_pkg::ST_IDLE: begin
            end
            bcd_pkg::ST_EXEC: begin
                if (cpu_tick) begin
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_nxt = bcd_pkg::ST_IDLE;
                        taken_nxt = cond;
                        pc_nxt = cond ? pc_jump : pc_seq;
                        case (instr_r.op)
                            bcd_pkg::OP_DEC_BR: begin
                                case (instr_r.src)
                                    bcd_pkg::DEC_REGB: regb_nxt = dec_val;
                                    bcd_pkg::DEC_REGC: regc_nxt = dec_val;
                                    default: opnd_nxt = dec_val;
                                endcase
                            end
                            bcd_pkg::OP_INT_ALLOW: psw_nxt[bcd_pkg::PSW_IE_BIT] = 1'b1;
                            bcd_pkg::OP_INT_BLOCK: psw_nxt[bcd_pkg::PSW_IE_BIT] = 1'b0;
                            bcd_pkg::OP_CLK_PAUSE: pause_nxt = 1'b1;
                            bcd_pkg::OP_OSC_FREEZE: freeze_nxt = 1'b1;
                            default: begin
                                // flags untouched by branches and idle
                            end
                        endcase
                    end
                end
            end
            default: state_nxt = bcd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= bcd_pkg::ST_IDLE;
            instr_r <= '0;
            aph_r <= '0;
            cnt_r <= 4'h0;
            div_r <= 3'h0;
            pc_r <= bcd_pkg::PC_RST;
            psw_r <= bcd_pkg::BYTE_RST;
            acc_r <= bcd_pkg::BYTE_RST;
            regb_r <= bcd_pkg::BYTE_RST;
            regc_r <= bcd_pkg::BYTE_RST;
            opnd_r <= bcd_pkg::BYTE_RST;
            clksel_r <= bcd_pkg::CLKSEL_RST;
            pause_r <= 1'b0;
            freeze_r <= 1'b0;
            taken_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            aph_r <= aph_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            pc_r <= pc_nxt;
            psw_r <= psw_nxt;
            acc_r <= acc_nxt;
            regb_r <= regb_nxt;
            regc_r <= regc_nxt;
            opnd_r <= opnd_nxt;
            clksel_r <= clksel_nxt;
            pause_r <= pause_nxt;
            freeze_r <= freeze_nxt;
            taken_r <= taken_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign busy = (state_r == bcd_pkg::ST_EXEC);
    assign interrupt_enable = psw_r[bcd_pkg::PSW_IE_BIT];
    assign clock_pause_mode = pause_r;
    assign oscillator_freeze_mode = freeze_r;

endmodule : bcd_core

// File: bcd_core_test.sv
module bcd_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, busy, interrupt_enable, clock_pause_mode, oscillator_freeze_mode;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] rst_a [4] = '{bcd_pkg::ADDR_PC, bcd_pkg::ADDR_PSW, bcd_pkg::ADDR_CLKSEL, 8'h80};
    int err_count = 0;
    int num_checks = 0;
    int sel_n = 1;
    assign hready = hreadyout;
    always #4 mclk = ~mclk;
    bcd_core DUT (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .busy(busy), .interrupt_enable(interrupt_enable),
        .clock_pause_mode(clock_pause_mode), .oscillator_freeze_mode(oscillator_freeze_mode));
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : bus
    task automatic run(input logic [3:0] op, input logic [1:0] src, input logic [2:0] bt,
            input logic [7:0] ofs, input logic [7:0] program_status_word, input logic [7:0] v,
            input int len, input int clk, input logic tk);
        logic [15:0] pc_exp;
        logic [7:0] psw_exp;
        logic [7:0] tgt;
        int n;
        pc_exp = 16'hfff8 + 16'(len) + (tk ? {{8{ofs[7]}}, ofs} : 16'h0);
        psw_exp = program_status_word & bcd_pkg::PSW_WMASK;
        if (op == 4'h8) psw_exp[bcd_pkg::PSW_IE_BIT] = 1'b1;
        if (op == 4'h9) psw_exp[bcd_pkg::PSW_IE_BIT] = 1'b0;
        tgt = (src == 2'h1) ? bcd_pkg::ADDR_REGB : bcd_pkg::ADDR_OPND;
        if (src == 2'h2) tgt = bcd_pkg::ADDR_REGC;
        if (op != 4'h7) tgt = bcd_pkg::ADDR_OPND;
        n = 0;
        bus(1'b1, bcd_pkg::ADDR_PC, 32'h0000fff8);
        bus(1'b1, bcd_pkg::ADDR_PSW, {24'h0, program_status_word});
        bus(1'b1, bcd_pkg::ADDR_ACC, {24'h0, v});
        bus(1'b1, bcd_pkg::ADDR_REGB, {24'h0, v});
        bus(1'b1, bcd_pkg::ADDR_REGC, {24'h0, v});
        bus(1'b1, bcd_pkg::ADDR_OPND, {24'h0, v});
        bus(1'b1, bcd_pkg::ADDR_INSTR, {8'h0, ofs, 5'h0, bt, 2'h0, src, op});
        bus(1'b1, bcd_pkg::ADDR_CTRL, 32'h1);
        // start commits at the last edge of bus: busy is seen from this one
        @(posedge mclk);
        while (busy === 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(n, clk * sel_n);
        bus(1'b0, bcd_pkg::ADDR_PC, 32'h0);
        chk(rd, {16'h0, pc_exp});
        bus(1'b0, bcd_pkg::ADDR_PSW, 32'h0);
        chk(rd, {24'h0, psw_exp});
        chk(interrupt_enable, psw_exp[bcd_pkg::PSW_IE_BIT]);
        bus(1'b0, bcd_pkg::ADDR_STATUS, 32'h0);
        chk(rd[bcd_pkg::STAT_TAKEN_BIT], tk);
        bus(1'b0, tgt, 32'h0);
        chk(rd, {24'h0, (op == 4'h7) ? v - 8'h1 : v});
    endtask : run
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        bus(1'b1, 8'h80, 32'hffffffff);
        foreach (rst_a[i]) begin
            bus(1'b0, rst_a[i], 32'h0);
            chk(rd, 32'h0);
        end
        run(4'h1, 2'h0, 3'h0, 8'h10, 8'h01, 8'h55, 2, 6, 1'b1);
        run(4'h1, 2'h0, 3'h0, 8'h10, 8'h50, 8'h55, 2, 6, 1'b0);
        run(4'h2, 2'h0, 3'h0, 8'h7f, 8'h00, 8'h55, 2, 6, 1'b1);
        run(4'h2, 2'h0, 3'h0, 8'h7f, 8'h11, 8'h55, 2, 6, 1'b0);
        run(4'h3, 2'h0, 3'h0, 8'hf0, 8'h40, 8'h55, 2, 6, 1'b1);
        run(4'h3, 2'h0, 3'h0, 8'hf0, 8'h91, 8'h55, 2, 6, 1'b0);
        run(4'h4, 2'h0, 3'h0, 8'h80, 8'h00, 8'h55, 2, 6, 1'b1);
        run(4'h4, 2'h0, 3'h0, 8'h80, 8'hd1, 8'h55, 2, 6, 1'b0);
        run(4'h5, 2'h0, 3'h7, 8'h20, 8'h00, 8'h80, 4, 10, 1'b1);
        run(4'h5, 2'h1, 3'h0, 8'h20, 8'h00, 8'hfe, 4, 10, 1'b0);
        run(4'h5, 2'h2, 3'h6, 8'h20, 8'h40, 8'h00, 4, 10, 1'b1);
        run(4'h5, 2'h3, 3'h3, 8'h20, 8'h00, 8'h08, 3, 8, 1'b1);
        run(4'h5, 2'h3, 3'h4, 8'h20, 8'h00, 8'hef, 3, 8, 1'b0);
        run(4'h6, 2'h0, 3'h2, 8'hfe, 8'h00, 8'hfb, 4, 10, 1'b1);
        run(4'h6, 2'h1, 3'h5, 8'hfe, 8'h00, 8'h20, 4, 10, 1'b0);
        run(4'h6, 2'h2, 3'h0, 8'hfe, 8'h01, 8'h00, 4, 10, 1'b0);
        run(4'h6, 2'h3, 3'h1, 8'hfe, 8'h00, 8'hfd, 3, 8, 1'b1);
        run(4'h6, 2'h3, 3'h7, 8'hfe, 8'h00, 8'h80, 3, 8, 1'b0);
        run(4'h7, 2'h1, 3'h0, 8'h04, 8'h00, 8'h02, 2, 6, 1'b1);
        run(4'h7, 2'h2, 3'h0, 8'h04, 8'h00, 8'h01, 2, 6, 1'b0);
        run(4'h7, 2'h0, 3'h0, 8'h04, 8'h00, 8'h00, 3, 8, 1'b1);
        run(4'h7, 2'h0, 3'h0, 8'h04, 8'h00, 8'h01, 3, 8, 1'b0);
        run(4'h0, 2'h0, 3'h0, 8'h04, 8'hd1, 8'h33, 1, 2, 1'b0);
        run(4'h8, 2'h0, 3'h0, 8'h04, 8'h00, 8'h33, 3, 6, 1'b0);
        run(4'h9, 2'h0, 3'h0, 8'h04, 8'h80, 8'h33, 3, 6, 1'b0);
        for (int s = 3; s >= 0; s--) begin
            bus(1'b1, bcd_pkg::ADDR_CLKSEL, s);
            sel_n = 1 << s;
            run(4'h5, 2'h0, 3'h0, 8'h08, 8'h00, 8'h01, 4, 10, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            run(4'ha + 4'(i), 2'h0, 3'h0, 8'h04, 8'h51, 8'h33, 1, 2, 1'b0);
            chk({oscillator_freeze_mode, clock_pause_mode}, i + 1);
            bus(1'b1, bcd_pkg::ADDR_CTRL, 32'h1);
            @(posedge mclk);
            chk(busy, 1'b0);
            bus(1'b1, bcd_pkg::ADDR_STATUS, 32'h0);
            @(posedge mclk);
            chk({oscillator_freeze_mode, clock_pause_mode}, 32'h0);
            chk(hresp, 1'b0);
        end
        stop_test();
    end
endmodule : bcd_core_test

// File: bcd_pkg.sv
package bcd_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INSTR = 8'h04;
    localparam logic [7:0] ADDR_PC = 8'h08;
    localparam logic [7:0] ADDR_PSW = 8'h0c;
    localparam logic [7:0] ADDR_ACC = 8'h10;
    localparam logic [7:0] ADDR_REGB = 8'h14;
    localparam logic [7:0] ADDR_REGC = 8'h18;
    localparam logic [7:0] ADDR_OPND = 8'h1c;
    localparam logic [7:0] ADDR_CLKSEL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // ctrl / status fields
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PAUSE_BIT = 1;
    localparam int STAT_FREEZE_BIT = 2;
    localparam int STAT_TAKEN_BIT = 3;

    // instruction word fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_SRC_LSB = 4;
    localparam int INSTR_BIT_LSB = 8;
    localparam int INSTR_OFS_LSB = 16;

    // program status word bit positions
    localparam int PSW_CY_BIT = 0;
    localparam int PSW_AC_BIT = 4;
    localparam int PSW_Z_BIT = 6;
    localparam int PSW_IE_BIT = 7;
    localparam logic [7:0] PSW_WMASK = 8'hd1;

    // reset values
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] CLKSEL_RST = 2'h0;

    // instruction lengths in bytes
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] LEN_4 = 3'h4;

    // instruction durations in cpu clocks
    localparam logic [3:0] CLK_2 = 4'h2;
    localparam logic [3:0] CLK_6 = 4'h6;
    localparam logic [3:0] CLK_8 = 4'h8;
    localparam logic [3:0] CLK_10 = 4'ha;

    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_BR_CARRY = 4'h1,
        OP_BR_NO_CARRY = 4'h2,
        OP_BR_ZERO = 4'h3,
        OP_BR_NONZERO = 4'h4,
        OP_BIT_SET = 4'h5,
        OP_BIT_CLEAR = 4'h6,
        OP_DEC_BR = 4'h7,
        OP_INT_ALLOW = 4'h8,
        OP_INT_BLOCK = 4'h9,
        OP_CLK_PAUSE = 4'ha,
        OP_OSC_FREEZE = 4'hb
    } bcd_op_e;

    // operand source: bit tests use all four, decrement uses short/b/c
    typedef enum logic [1:0] {
        SRC_SHORT = 2'h0,
        SRC_SFR = 2'h1,
        SRC_PSW = 2'h2,
        SRC_ACC = 2'h3
    } bcd_src_e;

    localparam logic [1:0] DEC_REGB = 2'h1;
    localparam logic [1:0] DEC_REGC = 2'h2;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } bcd_state_e;

    typedef struct packed {
        logic [7:0] offset;
        logic [2:0] bit_sel;
        logic [1:0] src;
        logic [3:0] op;
    } bcd_instr_s;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } bcd_aphase_s;

endpackage : bcd_pkg
